// *** pdm_pkg.sv ***
package pdm_pkg;

  localparam int PDM_AW     = 12;
  localparam int PDM_DW     = 16;
  localparam int PDM_PORT_W = 3;
  localparam int PDM_RAM_AW = 8;

  // Sizes of on-chip storage for each variant.
  localparam int PDM_RAM_SMALL = 144;
  localparam int PDM_RAM_LARGE = 256;
  localparam int PDM_ROM_SMALL = 1536;
  localparam int PDM_ROM_LARGE = 4096;

  // Highest program location open to user code; the rest of on-chip program memory is test space.
  localparam logic [11:0] PDM_USER_TOP_SMALL = 12'h5F3;
  localparam logic [11:0] PDM_USER_TOP_LARGE = 12'hF9F;

  // Last phase index of each operation: one, two or three instruction cycles.
  localparam logic [1:0] PDM_LAST_FETCH = 2'h0;
  localparam logic [1:0] PDM_LAST_PORT  = 2'h1;
  localparam logic [1:0] PDM_LAST_TABLE = 2'h2;
  localparam logic [1:0] PDM_IO_PHASE   = 2'h1;

  // Internal control register ports on the serial-port variant.
  localparam logic [2:0]  PDM_CTRL_PORT_LO = 3'h0;
  localparam logic [2:0]  PDM_CTRL_PORT_HI = 3'h1;
  localparam logic [31:0] PDM_CTRL_RESET   = 32'h0000_0000;
  localparam logic [15:0] PDM_WORD_ZERO    = 16'h0000;
  localparam logic [11:0] PDM_ADDR_RESET   = 12'h000;

  typedef enum logic [1:0] {
    PDM_VAR_SMALL,
    PDM_VAR_LARGE,
    PDM_VAR_SERIAL
  } pdm_variant_t;

  typedef enum logic [2:0] {
    PDM_OP_FETCH,
    PDM_OP_DATA_READ,
    PDM_OP_DATA_WRITE,
    PDM_OP_DATA_MOVE,
    PDM_OP_TABLE_READ,
    PDM_OP_TABLE_WRITE,
    PDM_OP_PORT_IN,
    PDM_OP_PORT_OUT
  } pdm_op_t;

  typedef enum logic [1:0] {
    PDM_SRC_EXT,
    PDM_SRC_ROM,
    PDM_SRC_VAL
  } pdm_src_t;

  typedef struct packed {
    pdm_op_t     op;
    logic [11:0] pc;
    logic [11:0] tbl_addr;
    logic [7:0]  dma;
    logic [2:0]  port;
    logic [15:0] wdata;
  } pdm_req_t;

  typedef struct packed {
    logic [11:0] addr;
    logic        mem_n;
    logic        den_n;
    logic        we_n;
    logic        d_oe;
  } pdm_bus_t;

  typedef struct packed {
    logic        valid;
    pdm_src_t    src;
    logic [7:0]  addr;
    logic [15:0] value;
  } pdm_tag_t;

endpackage : pdm_pkg

// *** pdm_data_ram.sv ***
`timescale 1ns/100ps
module pdm_data_ram #(
  parameter int DEPTH = 256
) (
  // Clock.
  input  wire logic        clk_sys,
  // Write port.
  input  wire logic        wr_en,
  input  wire logic [7:0]  wr_addr,
  input  wire logic [15:0] wr_data,
  // Read port with optional copy to the next location.
  input  wire logic        rd_en,
  input  wire logic        move_en,
  input  wire logic [7:0]  rd_addr,
  output logic      [15:0] rd_q
);

  logic [15:0] mem [DEPTH];
  logic [8:0]  up_addr;

  assign up_addr = {1'b0, rd_addr} + 9'h001;

  always_ff @(posedge clk_sys) begin
    if (rd_en && (int'(rd_addr) < DEPTH)) begin
      rd_q <= mem[rd_addr];
      if (move_en && (int'(up_addr) < DEPTH)) begin
        mem[up_addr[7:0]] <= mem[rd_addr];
      end
    end
    // A late result write lands after the copy, so it wins on the same word.
    if (wr_en && (int'(wr_addr) < DEPTH)) begin
      mem[wr_addr] <= wr_data;
    end
  end

endmodule : pdm_data_ram

// *** pdm_prog_store.sv ***
`timescale 1ns/100ps
module pdm_prog_store #(
  parameter int WORDS = 4096
) (
  // Clock.
  input  wire logic        clk_sys,
  // Programming port.
  input  wire logic        wr_en,
  input  wire logic [11:0] wr_addr,
  input  wire logic [15:0] wr_data,
  // Core read port.
  input  wire logic [11:0] rd_addr,
  output logic      [15:0] rd_q,
  // Verify port, seen from outside the device.
  input  wire logic        secure,
  input  wire logic [11:0] vfy_addr,
  output logic      [15:0] vfy_q
);

  logic [15:0] mem [WORDS];

  always_ff @(posedge clk_sys) begin
    if (wr_en && !secure && (int'(wr_addr) < WORDS)) begin
      mem[wr_addr] <= wr_data;
    end
    rd_q  <= (int'(rd_addr) < WORDS) ? mem[rd_addr] : pdm_pkg::PDM_WORD_ZERO;
    // Once secured, contents can no longer be read or altered from outside.
    vfy_q <= (secure || int'(vfy_addr) >= WORDS) ? pdm_pkg::PDM_WORD_ZERO
                                                 : mem[vfy_addr];
  end

endmodule : pdm_prog_store

// *** pdm_mem_if.sv ***
// Operation
// - Program and data memory are separate spaces on separate paths.
// - Data RAM holds 16-bit words: 144 small variant, 256 larger variants.
// - Table read copies program word into RAM; table write copies RAM word out.
// - Table read and table write each take three instruction cycles.
// - Port input and port output each take two instruction cycles.
// - Mode pin high selects microcomputer mode, fetching from internal program memory.
// - Mode pin low selects microprocessor mode.
// - Microprocessor mode fetches every instruction externally, no on-chip program memory.
// - Twelve address outputs carry program counter, table address or I/O port address.
// - Memory strobe goes low per fetch; external memory returns the instruction word.
// - Microcomputer mode still strobes and shows the program counter on address pins.
// - Memory strobe never low together with write or data-enable strobe.
// - Memory strobe low every busy cycle except port and table-write I/O cycles; high while idle.
// - In multicycle I/O operations, strobe low only where write/data-enable stay high.
// - Data move copies addressed RAM word upward while it is used as operand.
// - Three address spaces exist: program, data and I/O.
// - External fetches run at full speed without extra cycles.
// - Serial variant: ports 0 and 1 hit the control register; coprocessor blocks I/O.
// - Serial variant has no microprocessor mode and no program memory expansion.
// - EPROM variants can block external reading of on-chip program contents.
`timescale 1ns/100ps
module pdm_mem_if #(
  parameter pdm_pkg::pdm_variant_t VARIANT = pdm_pkg::PDM_VAR_LARGE
) (
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  // Device pins.
  input  wire logic              memory_mode_select,
  input  wire logic              coproc_mode,
  input  wire logic              secure_fuse,
  input  wire logic [15:0]       data_in,
  output logic      [15:0]       data_out,
  output pdm_pkg::pdm_bus_t      bus_pins,
  // Core request side.
  input  wire logic              req_valid,
  input  wire pdm_pkg::pdm_req_t req,
  output logic                   req_ready,
  output logic                   instr_valid,
  output logic      [15:0]       instr,
  output logic                   operand_valid,
  output logic      [15:0]       operand,
  // Program store maintenance.
  input  wire logic              prog_wr_en,
  input  wire logic [11:0]       prog_wr_addr,
  input  wire logic [15:0]       prog_wr_data,
  input  wire logic [11:0]       verify_addr,
  output logic      [15:0]       verify_data,
  // Control register of the serial variant.
  output logic      [31:0]       ctrl_reg
);

  localparam bit HAS_CTRL  = (VARIANT == pdm_pkg::PDM_VAR_SERIAL);
  localparam int RAM_DEPTH = (VARIANT == pdm_pkg::PDM_VAR_SMALL) ? pdm_pkg::PDM_RAM_SMALL
                                                                 : pdm_pkg::PDM_RAM_LARGE;
  localparam int ROM_WORDS = (VARIANT == pdm_pkg::PDM_VAR_SMALL) ? pdm_pkg::PDM_ROM_SMALL
                                                                 : pdm_pkg::PDM_ROM_LARGE;

  function automatic logic [1:0] pdm_last(input pdm_pkg::pdm_op_t op);
    case (op)
      pdm_pkg::PDM_OP_TABLE_READ,
      pdm_pkg::PDM_OP_TABLE_WRITE: pdm_last = pdm_pkg::PDM_LAST_TABLE;
      pdm_pkg::PDM_OP_PORT_IN,
      pdm_pkg::PDM_OP_PORT_OUT:    pdm_last = pdm_pkg::PDM_LAST_PORT;
      default:                     pdm_last = pdm_pkg::PDM_LAST_FETCH;
    endcase
  endfunction : pdm_last

  function automatic logic pdm_is_io(input pdm_pkg::pdm_op_t op, input logic [1:0] ph);
    pdm_is_io = (ph == pdm_pkg::PDM_IO_PHASE) &&
                (op == pdm_pkg::PDM_OP_TABLE_WRITE || op == pdm_pkg::PDM_OP_PORT_IN ||
                 op == pdm_pkg::PDM_OP_PORT_OUT);
  endfunction : pdm_is_io

  // Pin synchronisers.
  logic        mode_s1_reg;
  logic        mode_s2_reg;
  logic        cop_s1_reg;
  logic        cop_s2_reg;
  logic        sec_s1_reg;
  logic        sec_s2_reg;
  logic [15:0] din_s1_reg;
  logic [15:0] din_s2_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      mode_s1_reg <= 1'b0;
      mode_s2_reg <= 1'b0;
      cop_s1_reg  <= 1'b0;
      cop_s2_reg  <= 1'b0;
      sec_s1_reg  <= 1'b0;
      sec_s2_reg  <= 1'b0;
      din_s1_reg  <= pdm_pkg::PDM_WORD_ZERO;
      din_s2_reg  <= pdm_pkg::PDM_WORD_ZERO;
    end else begin
      mode_s1_reg <= memory_mode_select;
      mode_s2_reg <= mode_s1_reg;
      cop_s1_reg  <= coproc_mode;
      cop_s2_reg  <= cop_s1_reg;
      sec_s1_reg  <= secure_fuse;
      sec_s2_reg  <= sec_s1_reg;
      din_s1_reg  <= data_in;
      din_s2_reg  <= din_s1_reg;
    end
  end

  // The serial variant has no external program space, so it is always microcomputer.
  logic mc_mode;
  assign mc_mode = HAS_CTRL ? 1'b1 : mode_s2_reg;

  function automatic logic pdm_internal(input logic mc, input logic [11:0] a);
    pdm_internal = mc && (int'(a) < ROM_WORDS);
  endfunction : pdm_internal

  // Operation sequencer.
  logic              busy_reg;
  logic [1:0]        phase_reg;
  pdm_pkg::pdm_req_t req_reg;
  logic              busy_next;
  logic [1:0]        phase_next;
  pdm_pkg::pdm_req_t req_next;
  logic              last_phase;
  logic              accept;
  logic              stay;

  assign last_phase = busy_reg && (phase_reg == pdm_last(req_reg.op));
  assign req_ready  = !busy_reg || last_phase;
  assign accept     = req_valid && req_ready;
  assign stay       = busy_reg && !last_phase;
  assign busy_next  = stay || accept;
  assign phase_next = stay ? phase_reg + 2'h1 : 2'h0;
  assign req_next   = stay ? req_reg : req;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy_reg  <= 1'b0;
      phase_reg <= 2'h0;
      req_reg   <= '0;
    end else begin
      busy_reg  <= busy_next;
      phase_reg <= phase_next;
      req_reg   <= req_next;
    end
  end

  // In the serial variant ports 0 and 1 stay inside and coprocessor mode shuts external I/O; other variants ignore coprocessor mode.
  function automatic logic pdm_ext_io(input logic [2:0] port, input logic cop);
    pdm_ext_io = !HAS_CTRL ||
                 (!cop && port != pdm_pkg::PDM_CTRL_PORT_LO && port != pdm_pkg::PDM_CTRL_PORT_HI);
  endfunction : pdm_ext_io

  function automatic pdm_pkg::pdm_bus_t pdm_drive(input logic busy,
                                                  input logic [1:0] ph,
                                                  input pdm_pkg::pdm_req_t r,
                                                  input logic cop);
    pdm_pkg::pdm_bus_t b;
    b.addr  = r.pc;
    b.mem_n = !busy;
    b.den_n = 1'b1;
    b.we_n  = 1'b1;
    b.d_oe  = 1'b0;
    if (busy && ph == pdm_pkg::PDM_IO_PHASE) begin
      case (r.op)
        pdm_pkg::PDM_OP_TABLE_READ: b.addr = r.tbl_addr;
        pdm_pkg::PDM_OP_TABLE_WRITE: begin
          b.addr  = r.tbl_addr;
          b.mem_n = 1'b1;
          b.we_n  = 1'b0;
          b.d_oe  = 1'b1;
        end
        pdm_pkg::PDM_OP_PORT_IN: begin
          b.addr  = {9'h000, r.port};
          b.mem_n = 1'b1;
          b.den_n = !pdm_ext_io(r.port, cop);
        end
        pdm_pkg::PDM_OP_PORT_OUT: begin
          b.addr  = {9'h000, r.port};
          b.mem_n = 1'b1;
          b.we_n  = !pdm_ext_io(r.port, cop);
          b.d_oe  = pdm_ext_io(r.port, cop);
        end
        default: b.addr = r.pc;
      endcase
    end
    return b;
  endfunction : pdm_drive

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_pins <= '{addr: pdm_pkg::PDM_ADDR_RESET, mem_n: 1'b1, den_n: 1'b1,
                    we_n: 1'b1, d_oe: 1'b0};
    end else begin
      bus_pins <= pdm_drive(busy_next, phase_next, req_next, cop_s2_reg);
    end
  end

  // Current-cycle decode.
  logic fetch_cyc;
  logic io_cyc;
  logic ram_rd;
  assign fetch_cyc = busy_reg && (phase_reg == 2'h0);
  assign io_cyc    = busy_reg && (phase_reg == pdm_pkg::PDM_IO_PHASE);
  assign ram_rd    = fetch_cyc && (req_reg.op == pdm_pkg::PDM_OP_DATA_READ  ||
                                   req_reg.op == pdm_pkg::PDM_OP_DATA_MOVE  ||
                                   req_reg.op == pdm_pkg::PDM_OP_TABLE_WRITE ||
                                   req_reg.op == pdm_pkg::PDM_OP_PORT_OUT);

  // Storage.
  logic [15:0] rom_q;
  logic [15:0] ram_q;
  logic        ram_wr;
  logic [7:0]  ram_wr_addr;
  logic [15:0] ram_wr_data;

  pdm_prog_store #(
    .WORDS (ROM_WORDS)
  ) u_prog (
    .clk_sys  (clk_sys),
    .wr_en    (prog_wr_en),
    .wr_addr  (prog_wr_addr),
    .wr_data  (prog_wr_data),
    .rd_addr  (bus_pins.addr),
    .rd_q     (rom_q),
    .secure   (sec_s2_reg),
    .vfy_addr (verify_addr),
    .vfy_q    (verify_data)
  );

  pdm_data_ram #(
    .DEPTH (RAM_DEPTH)
  ) u_ram (
    .clk_sys (clk_sys),
    .wr_en   (ram_wr),
    .wr_addr (ram_wr_addr),
    .wr_data (ram_wr_data),
    .rd_en   (ram_rd),
    .move_en (req_reg.op == pdm_pkg::PDM_OP_DATA_MOVE),
    .rd_addr (req_reg.dma),
    .rd_q    (ram_q)
  );

  // The RAM word read in phase 0 is held in the RAM output flop for the write cycle.
  assign data_out = ram_q;

  // Results return three edges after their bus cycle, matching the data pin synchroniser.
  logic        iv1_reg;
  logic        iv2_reg;
  logic        iint1_reg;
  logic        iint2_reg;
  logic [15:0] rom_q2_reg;
  pdm_pkg::pdm_tag_t tag1_reg;
  pdm_pkg::pdm_tag_t tag2_reg;
  pdm_pkg::pdm_tag_t tag_next;
  logic [15:0] ctrl_half;

  assign ctrl_half = (req_reg.port == pdm_pkg::PDM_CTRL_PORT_HI) ? ctrl_reg[31:16]
                                                                   : ctrl_reg[15:0];

  always_comb begin
    tag_next = '0;
    if (fetch_cyc && req_reg.op == pdm_pkg::PDM_OP_DATA_WRITE) begin
      tag_next = '{valid: 1'b1, src: pdm_pkg::PDM_SRC_VAL, addr: req_reg.dma,
                   value: req_reg.wdata};
    end else if (io_cyc && req_reg.op == pdm_pkg::PDM_OP_TABLE_READ) begin
      tag_next = '{valid: 1'b1,
                   src: pdm_internal(mc_mode, req_reg.tbl_addr) ? pdm_pkg::PDM_SRC_ROM
                                                                : pdm_pkg::PDM_SRC_EXT,
                   addr: req_reg.dma, value: pdm_pkg::PDM_WORD_ZERO};
    end else if (io_cyc && req_reg.op == pdm_pkg::PDM_OP_PORT_IN) begin
      tag_next = '{valid: 1'b1,
                   src: pdm_ext_io(req_reg.port, cop_s2_reg) ? pdm_pkg::PDM_SRC_EXT
                                                             : pdm_pkg::PDM_SRC_VAL,
                   addr: req_reg.dma,
                   value: (HAS_CTRL && !cop_s2_reg) ? ctrl_half
                                                    : pdm_pkg::PDM_WORD_ZERO};
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      iv1_reg    <= 1'b0;
      iv2_reg    <= 1'b0;
      iint1_reg  <= 1'b0;
      iint2_reg  <= 1'b0;
      rom_q2_reg <= pdm_pkg::PDM_WORD_ZERO;
      tag1_reg   <= '0;
      tag2_reg   <= '0;
    end else begin
      iv1_reg    <= fetch_cyc;
      iint1_reg  <= fetch_cyc && pdm_internal(mc_mode, req_reg.pc);
      iv2_reg    <= iv1_reg;
      iint2_reg  <= iint1_reg;
      rom_q2_reg <= rom_q;
      tag1_reg   <= tag_next;
      tag2_reg   <= tag1_reg;
    end
  end

  assign ram_wr      = tag2_reg.valid;
  assign ram_wr_addr = tag2_reg.addr;
  assign ram_wr_data = (tag2_reg.src == pdm_pkg::PDM_SRC_EXT) ? din_s2_reg :
                       (tag2_reg.src == pdm_pkg::PDM_SRC_ROM) ? rom_q2_reg : tag2_reg.value;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      instr_valid <= 1'b0;
      instr       <= pdm_pkg::PDM_WORD_ZERO;
    end else begin
      instr_valid <= iv2_reg;
      if (iv2_reg) begin
        instr <= iint2_reg ? rom_q2_reg : din_s2_reg;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      operand_valid <= 1'b0;
    end else begin
      operand_valid <= fetch_cyc && (req_reg.op == pdm_pkg::PDM_OP_DATA_READ ||
                                     req_reg.op == pdm_pkg::PDM_OP_DATA_MOVE);
    end
  end
  assign operand = ram_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= pdm_pkg::PDM_CTRL_RESET;
    end else if (HAS_CTRL && io_cyc && req_reg.op == pdm_pkg::PDM_OP_PORT_OUT &&
                 !cop_s2_reg) begin
      if (req_reg.port == pdm_pkg::PDM_CTRL_PORT_LO) begin
        ctrl_reg[15:0] <= ram_q;
      end else if (req_reg.port == pdm_pkg::PDM_CTRL_PORT_HI) begin
        ctrl_reg[31:16] <= ram_q;
      end
    end
  end

  // Checks.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_strobe_exclusive: assert property (!bus_pins.mem_n |-> (bus_pins.we_n && bus_pins.den_n))
    else $error("memory strobe overlaps write or data enable");
  a_strobe_busy_low: assert property ((busy_reg && !pdm_is_io(req_reg.op, phase_reg)) |-> !bus_pins.mem_n)
    else $error("memory strobe high outside an I/O cycle");
  a_table_write_seq: assert property ((accept && req.op == pdm_pkg::PDM_OP_TABLE_WRITE) |=>
    !bus_pins.mem_n ##1 (bus_pins.mem_n && !bus_pins.we_n && bus_pins.d_oe) ##1 !bus_pins.mem_n)
    else $error("table write strobe pattern wrong");
  a_table_three_cyc: assert property ((accept && (req.op == pdm_pkg::PDM_OP_TABLE_READ ||
    req.op == pdm_pkg::PDM_OP_TABLE_WRITE)) |=> !req_ready [*2] ##1 req_ready)
    else $error("table operation not three cycles");
  a_port_two_cyc: assert property ((accept && (req.op == pdm_pkg::PDM_OP_PORT_IN ||
    req.op == pdm_pkg::PDM_OP_PORT_OUT)) |=> !req_ready ##1 req_ready)
    else $error("port operation not two cycles");
  a_fetch_addr_pc: assert property (fetch_cyc |-> (bus_pins.addr == req_reg.pc && !bus_pins.mem_n))
    else $error("fetch cycle does not show the program counter");
  a_fetch_full_speed: assert property (fetch_cyc |-> ##3 instr_valid)
    else $error("fetched instruction late");
  a_mp_external_src: assert property ((fetch_cyc && !mc_mode) |=> !iint1_reg)
    else $error("internal program memory used in microprocessor mode");
  a_port_addr_out: assert property ((io_cyc && req_reg.op == pdm_pkg::PDM_OP_PORT_IN &&
    pdm_ext_io(req_reg.port, cop_s2_reg)) |-> (bus_pins.addr[11:3] == 9'h000 && !bus_pins.den_n))
    else $error("port address or data enable wrong");
  a_ctrl_port_quiet: assert property ((io_cyc && HAS_CTRL && !pdm_ext_io(req_reg.port, cop_s2_reg))
    |-> (bus_pins.we_n && bus_pins.den_n))
    else $error("internal port reached the external bus");
  a_move_operand: assert property ((fetch_cyc && req_reg.op == pdm_pkg::PDM_OP_DATA_MOVE) |=> operand_valid)
    else $error("data move gave no operand");

  c_table_read:  cover property (accept && req.op == pdm_pkg::PDM_OP_TABLE_READ ##4 ram_wr);
  c_table_write: cover property (!bus_pins.we_n && bus_pins.d_oe);
  c_port_in:     cover property (!bus_pins.den_n ##2 ram_wr);
  c_data_move:   cover property (fetch_cyc && req_reg.op == pdm_pkg::PDM_OP_DATA_MOVE);

endmodule : pdm_mem_if

// *** pdm_ext_mem.sv ***
`timescale 1ns/100ps
module pdm_ext_mem (
  // Clock.
  input  wire logic              clk_sys,
  // Device bus.
  input  wire pdm_pkg::pdm_bus_t bus_pins,
  input  wire logic [15:0]       dev_data,
  output logic      [15:0]       bus_data
);
  logic [15:0] mem [0:4095];
  logic [15:0] port_q [0:7];
  logic [15:0] last_q = 16'h0000;

  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = {4'hA, 12'(i)};
    for (int i = 0; i < 8; i++) port_q[i] = 16'h5000 | 16'(i);
  end

  // A released bus does not keep its last word, so the core cannot profit from a stale value.
  always_comb begin
    if (bus_pins.mem_n === 1'b0) bus_data = mem[bus_pins.addr];
    else if (bus_pins.den_n === 1'b0) bus_data = port_q[bus_pins.addr[2:0]];
    else bus_data = ~last_q;
  end

  // Address decoding is loose: a low address also lands in the peripheral latch.
  always @(posedge clk_sys) begin
    if (bus_pins.mem_n === 1'b0 || bus_pins.den_n === 1'b0) last_q <= bus_data;
    if (bus_pins.we_n === 1'b0 && bus_pins.d_oe === 1'b1) begin
      mem[bus_pins.addr] <= dev_data;
      if (bus_pins.addr[11:3] == 9'h000) port_q[bus_pins.addr[2:0]] <= dev_data;
    end
  end
endmodule : pdm_ext_mem

// *** pdm_mem_if_tb.sv ***
`timescale 1ns/100ps
module pdm_mem_if_tb;
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  logic              memory_mode_select = 1'b0;
  logic              secure_fuse = 1'b0;
  logic              req_valid = 1'b0;
  logic              prog_wr_en = 1'b0;
  logic [11:0]       prog_wr_addr = 12'h000;
  logic [15:0]       prog_wr_data = 16'h0000;
  logic [11:0]       verify_addr = 12'h000;
  pdm_pkg::pdm_req_t req = '0;
  pdm_pkg::pdm_bus_t bus_pins;
  logic [15:0]       data_in, data_out, instr, operand, verify_data, got_ins, got_opd;
  logic              req_ready, instr_valid, operand_valid;
  logic [11:0]       addr0, io_addr;
  int                err_total = 0, checks_done = 0, cyc = 0;
  int                men_cnt, io_cnt, ovl_cnt, ins_at, men_at;

  pdm_mem_if dut (.clk_sys(clk_sys), .rstn(rstn), .memory_mode_select(memory_mode_select),
    .coproc_mode(1'b0), .secure_fuse(secure_fuse), .data_in(data_in), .data_out(data_out),
    .bus_pins(bus_pins), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .instr_valid(instr_valid), .instr(instr), .operand_valid(operand_valid),
    .operand(operand), .prog_wr_en(prog_wr_en), .prog_wr_addr(prog_wr_addr),
    .prog_wr_data(prog_wr_data), .verify_addr(verify_addr), .verify_data(verify_data),
    .ctrl_reg());
  pdm_ext_mem ext (.clk_sys(clk_sys), .bus_pins(bus_pins), .dev_data(data_out),
    .bus_data(data_in));

  initial forever #5 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Issues one operation and watches the pins for eight cycles, long enough for every write
  // in the core's pipeline to land before the next operation reads it.
  task automatic run_op(input pdm_pkg::pdm_op_t op, input logic [11:0] pc, input logic [11:0] tbl,
                        input logic [7:0] dma, input logic [2:0] port, input logic [15:0] wd);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req <= '{op: op, pc: pc, tbl_addr: tbl, dma: dma, port: port, wdata: wd};
    // Ready is judged once it has settled, so the accepting edge is the next one.
    #1;
    while (req_ready !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    req_valid <= 1'b0;
    men_cnt = 0; io_cnt = 0; ovl_cnt = 0; ins_at = -1; men_at = -1;
    for (int i = 0; i < 8; i++) begin
      #1;
      if (bus_pins.mem_n === 1'b0) begin
        men_cnt++;
        if (men_at < 0) begin men_at = i; addr0 = bus_pins.addr; end
      end
      if (bus_pins.we_n === 1'b0 || bus_pins.den_n === 1'b0) begin
        io_cnt++;
        io_addr = bus_pins.addr;
        if (bus_pins.mem_n === 1'b0) ovl_cnt++;
      end
      if (instr_valid === 1'b1) begin got_ins = instr; ins_at = i; end
      if (operand_valid === 1'b1) got_opd = operand;
      @(posedge clk_sys);
    end
  endtask : run_op

  task automatic t_ext_fetch();
    memory_mode_select <= 1'b0;
    repeat (4) @(posedge clk_sys);
    run_op(pdm_pkg::PDM_OP_FETCH, 12'h123, 12'h000, 8'h00, 3'h0, 16'h0000);
    chk("ext instr", got_ins, 16'hA123);
    chk("fetch addr", addr0, 12'h123);
    chk("fetch strobes", men_cnt, 1);
    chk("fetch latency", ins_at - men_at, 3);
    $display("external fetch done");
  endtask : t_ext_fetch

  task automatic t_table();
    run_op(pdm_pkg::PDM_OP_TABLE_READ, 12'h200, 12'hE80, 8'h05, 3'h0, 16'h0000);
    chk("table_read_op strobes", men_cnt, 3);
    run_op(pdm_pkg::PDM_OP_DATA_READ, 12'h201, 12'h000, 8'h05, 3'h0, 16'h0000);
    chk("table_read_op word", got_opd, 16'hAE80);
    run_op(pdm_pkg::PDM_OP_TABLE_WRITE, 12'h202, 12'hC40, 8'h05, 3'h0, 16'h0000);
    chk("table_write_op word", ext.mem[12'hC40], 16'hAE80);
    chk("table_write_op strobes", men_cnt, 2);
    chk("table_write_op writes", io_cnt, 1);
    chk("table_write_op overlap", ovl_cnt, 0);
    $display("table transfers done");
  endtask : t_table

  task automatic t_port();
    run_op(pdm_pkg::PDM_OP_PORT_IN, 12'h210, 12'h000, 8'h20, 3'h6, 16'h0000);
    chk("in strobes", men_cnt + 10 * io_cnt, 11);
    chk("in addr", io_addr, 12'h006);
    chk("in overlap", ovl_cnt, 0);
    run_op(pdm_pkg::PDM_OP_DATA_READ, 12'h211, 12'h000, 8'h20, 3'h0, 16'h0000);
    chk("in word", got_opd, 16'h5006);
    run_op(pdm_pkg::PDM_OP_PORT_OUT, 12'h212, 12'h000, 8'h20, 3'h2, 16'h0000);
    chk("out word", ext.port_q[2], 16'h5006);
    chk("out strobes", men_cnt + 10 * io_cnt, 11);
    $display("port transfers done");
  endtask : t_port

  task automatic t_move();
    run_op(pdm_pkg::PDM_OP_DATA_WRITE, 12'h220, 12'h000, 8'hFF, 3'h0, 16'h0F0F);
    run_op(pdm_pkg::PDM_OP_DATA_READ, 12'h221, 12'h000, 8'hFF, 3'h0, 16'h0000);
    chk("top ram word", got_opd, 16'h0F0F);
    run_op(pdm_pkg::PDM_OP_DATA_WRITE, 12'h222, 12'h000, 8'h30, 3'h0, 16'hBEEF);
    run_op(pdm_pkg::PDM_OP_DATA_MOVE, 12'h223, 12'h000, 8'h30, 3'h0, 16'h0000);
    chk("move operand", got_opd, 16'hBEEF);
    run_op(pdm_pkg::PDM_OP_DATA_READ, 12'h224, 12'h000, 8'h31, 3'h0, 16'h0000);
    chk("moved word", got_opd, 16'hBEEF);
    $display("data move done");
  endtask : t_move

  task automatic t_int_fetch();
    @(posedge clk_sys);
    prog_wr_en <= 1'b1; prog_wr_addr <= 12'h045; prog_wr_data <= 16'h1234;
    memory_mode_select <= 1'b1;
    @(posedge clk_sys);
    prog_wr_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    run_op(pdm_pkg::PDM_OP_FETCH, 12'h045, 12'h000, 8'h00, 3'h0, 16'h0000);
    chk("int instr", got_ins, 16'h1234);
    chk("int strobes", men_cnt, 1);
    chk("int addr", addr0, 12'h045);
    verify_addr <= 12'h045;
    repeat (3) @(posedge clk_sys);
    chk("verify open", verify_data, 16'h1234);
    secure_fuse <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk("verify locked", verify_data, 16'h0000);
    $display("internal fetch and security done");
  endtask : t_int_fetch

  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_ext_fetch();
    t_table();
    t_port();
    t_move();
    t_int_fetch();
    results();
  end
endmodule : pdm_mem_if_tb
